/* logic/octal_phy_pkg.sv */
// constants and carrier types of the octal ddr data lane
package octal_phy_pkg;

  // ****************************************************************
  // pad geometry
  // ****************************************************************
  localparam int DQ_PADS = 8;
  localparam int STB_PADS = 2;
  localparam int RX_WIDTH = 2 * DQ_PADS;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int FABRIC_CLOCK_HZ = 10_000_000;
  localparam int FABRIC_CLOCK_PERIOD_NS = 1_000_000_000 / FABRIC_CLOCK_HZ;
  // gate latency counted in half system cycles
  localparam int GATE_LAT_HALFCYC = 7;
  localparam int GATE_LAT_CYC = (GATE_LAT_HALFCYC + 1) / 2;
  localparam int INIT_TIME_NS = 1000;
  localparam int INIT_CYC =
    (INIT_TIME_NS + FABRIC_CLOCK_PERIOD_NS - 1) / FABRIC_CLOCK_PERIOD_NS;
  localparam int RX_FIFO_DEPTH = 8;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [RX_WIDTH-1:0] RX_DATA_RST = 16'h0000;
  localparam logic [DQ_PADS-1:0] DQ_OE_RST = 8'h00;
  localparam logic [STB_PADS-1:0] STB_OE_RST = 2'h0;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [RX_WIDTH-1:0] dqPair;
    logic [DQ_PADS-1:0] dqOe;
    logic [2*STB_PADS-1:0] stbPair;
    logic [STB_PADS-1:0] stbOe;
  } tx_pad_t;

  typedef struct packed {
    logic [RX_WIDTH-1:0] data;
    logic [RX_WIDTH-1:0] valid;
  } rx_word_t;

endpackage : octal_phy_pkg

/* logic/sync_fifo.sv */
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module sync_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic fabric_clock,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [AW-1:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
  logic [CW-1:0] count_r, count_nxt;
  logic push, pop;

  assign inReady = (count_r != FULL);
  assign outValid = (count_r != '0);
  assign outData = mem_r[rdPtr_r];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb
  begin
    mem_nxt = mem_r;
    wrPtr_nxt = wrPtr_r;
    rdPtr_nxt = rdPtr_r;
    count_nxt = count_r;
    if (push)
    begin
      mem_nxt[wrPtr_r] = inData;
      wrPtr_nxt = (wrPtr_r == LAST) ? '0 : wrPtr_r + 1'b1;
    end
    if (pop)
      rdPtr_nxt = (rdPtr_r == LAST) ? '0 : rdPtr_r + 1'b1;
    if (push && !pop)
      count_nxt = count_r + 1'b1;
    else if (pop && !push)
      count_nxt = count_r - 1'b1;
  end

  always_ff @(posedge fabric_clock or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_r[i] <= '0;
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      mem_r <= mem_nxt;
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
      count_r <= count_nxt;
    end
  end

endmodule : sync_fifo

/* logic/octal_ddr_phy_data_lane.sv */
// octal ddr phy data lane: pad transmit, gated strobe receive, fifo
// Summary of operation
// - only gated strobe edges load receive fifo
// - pad enables taken from fabric each clock once ready, held at reset values before
// - receive valid flags mark delivered data bits
// - gate reaches fifo after fixed latency
// - ready rises when initialization completes
`timescale 1ns/1ps
module octal_ddr_phy_data_lane #(
  parameter int FIFO_DEPTH = octal_phy_pkg::RX_FIFO_DEPTH
) (
  input wire logic fabric_clock,
  input wire logic rst,
  output logic phyReady,
  input wire octal_phy_pkg::tx_pad_t txIn,
  input wire logic [octal_phy_pkg::STB_PADS-1:0] stbGate,
  input wire logic [octal_phy_pkg::DQ_PADS-1:0] dqIn,
  output logic [octal_phy_pkg::DQ_PADS-1:0] dqOutRise,
  output logic [octal_phy_pkg::DQ_PADS-1:0] dqOutFall,
  output logic [octal_phy_pkg::DQ_PADS-1:0] dqOe,
  input wire logic stbIn,
  output logic [octal_phy_pkg::STB_PADS-1:0] stbOutRise,
  output logic [octal_phy_pkg::STB_PADS-1:0] stbOutFall,
  output logic [octal_phy_pkg::STB_PADS-1:0] stbOe,
  output logic stbRxRaw,
  output logic [octal_phy_pkg::DQ_PADS-1:0] dqRxRaw,
  output octal_phy_pkg::rx_word_t rxOut,
  input wire logic rxReady,
  output logic rxOverflow,
  output logic rxFrameError
);
  import octal_phy_pkg::*;

  localparam int ICW = $clog2(INIT_CYC + 1);
  localparam logic [ICW-1:0] INIT_LAST = ICW'(INIT_CYC - 1);

  // ****************************************************************
  // initialization and ready
  // ****************************************************************
  logic [ICW-1:0] initCnt_r, initCnt_nxt;
  logic ready_r, ready_nxt;

  always_comb
  begin
    initCnt_nxt = initCnt_r;
    ready_nxt = ready_r;
    if (!ready_r)
    begin
      if (initCnt_r == INIT_LAST)
        ready_nxt = 1'b1;
      else
        initCnt_nxt = initCnt_r + 1'b1;
    end
  end

  always_ff @(posedge fabric_clock or posedge rst)
  begin
    if (rst)
    begin
      initCnt_r <= '0;
      ready_r <= 1'b0;
    end
    else
    begin
      initCnt_r <= initCnt_nxt;
      ready_r <= ready_nxt;
    end
  end

  assign phyReady = ready_r;

  // ****************************************************************
  // transmit pads
  // ****************************************************************
  tx_pad_t txPad_r, txPad_nxt;

  always_comb
  begin
    txPad_nxt = txIn;
    if (!ready_r)
    begin
      txPad_nxt.dqOe = DQ_OE_RST;
      txPad_nxt.stbOe = STB_OE_RST;
    end
  end

  always_ff @(posedge fabric_clock or posedge rst)
  begin
    if (rst)
      txPad_r <= '0;
    else
      txPad_r <= txPad_nxt;
  end

  assign dqOutRise = txPad_r.dqPair[DQ_PADS-1:0];
  assign dqOutFall = txPad_r.dqPair[RX_WIDTH-1:DQ_PADS];
  assign dqOe = txPad_r.dqOe;
  assign stbOutRise = txPad_r.stbPair[STB_PADS-1:0];
  assign stbOutFall = txPad_r.stbPair[2*STB_PADS-1:STB_PADS];
  assign stbOe = txPad_r.stbOe;

  // ****************************************************************
  // receive: synchronisers, edges, gate delay, word assembly
  // ****************************************************************
  logic stbS1_r, stbS2_r, stbPrev_r;
  logic [DQ_PADS-1:0] dqS1_r, dqS2_r;
  logic [STB_PADS-1:0] gateDly_r [GATE_LAT_CYC];
  logic [STB_PADS-1:0] gateDly_nxt [GATE_LAT_CYC];
  logic [STB_PADS-1:0] gateAtFifo;
  logic [DQ_PADS-1:0] lowHalf_r, lowHalf_nxt;
  logic half_r, half_nxt;
  logic pendValid_r, pendValid_nxt;
  logic [RX_WIDTH-1:0] pendWord_r, pendWord_nxt;
  logic ovf_r, ovf_nxt, ferr_r, ferr_nxt;
  logic riseOk, fallOk, wordDone, fifoReady;

  assign gateAtFifo = gateDly_r[GATE_LAT_CYC-1];
  assign riseOk = ready_r && stbS2_r && !stbPrev_r && gateAtFifo[0];
  assign fallOk = ready_r && !stbS2_r && stbPrev_r && gateAtFifo[1];
  assign wordDone = fallOk && half_r;

  always_comb
  begin
    gateDly_nxt[0] = stbGate;
    for (int i = 1; i < GATE_LAT_CYC; i++)
      gateDly_nxt[i] = gateDly_r[i-1];
    lowHalf_nxt = lowHalf_r;
    half_nxt = half_r;
    pendValid_nxt = pendValid_r && !fifoReady;
    pendWord_nxt = pendWord_r;
    ovf_nxt = ovf_r;
    ferr_nxt = ferr_r;
    if (riseOk)
    begin
      lowHalf_nxt = dqS2_r;
      half_nxt = 1'b1;
    end
    else if (wordDone)
    begin
      half_nxt = 1'b0;
      if (pendValid_r && !fifoReady)
        ovf_nxt = 1'b1;
      else
      begin
        pendValid_nxt = 1'b1;
        pendWord_nxt = {dqS2_r, lowHalf_r};
      end
    end
    else if (fallOk)
      ferr_nxt = 1'b1;
    else if (half_r && gateAtFifo == '0)
    begin
      half_nxt = 1'b0;
      ferr_nxt = 1'b1;
    end
  end

  always_ff @(posedge fabric_clock or posedge rst)
  begin
    if (rst)
    begin
      stbS1_r <= 1'b0;
      stbS2_r <= 1'b0;
      stbPrev_r <= 1'b0;
      dqS1_r <= '0;
      dqS2_r <= '0;
      for (int i = 0; i < GATE_LAT_CYC; i++)
        gateDly_r[i] <= '0;
      lowHalf_r <= '0;
      half_r <= 1'b0;
      pendValid_r <= 1'b0;
      pendWord_r <= RX_DATA_RST;
      ovf_r <= 1'b0;
      ferr_r <= 1'b0;
    end
    else
    begin
      stbS1_r <= stbIn;
      stbS2_r <= stbS1_r;
      stbPrev_r <= stbS2_r;
      dqS1_r <= dqIn;
      dqS2_r <= dqS1_r;
      gateDly_r <= gateDly_nxt;
      lowHalf_r <= lowHalf_nxt;
      half_r <= half_nxt;
      pendValid_r <= pendValid_nxt;
      pendWord_r <= pendWord_nxt;
      ovf_r <= ovf_nxt;
      ferr_r <= ferr_nxt;
    end
  end

  assign stbRxRaw = stbS2_r;
  assign dqRxRaw = dqS2_r;
  assign rxOverflow = ovf_r;
  assign rxFrameError = ferr_r;

  // ****************************************************************
  // receive fifo and fabric output register
  // ****************************************************************
  logic fifoValid, pop;
  logic [RX_WIDTH-1:0] fifoData;
  rx_word_t rxOut_r, rxOut_nxt;

  sync_fifo #(
    .WIDTH(RX_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .fabric_clock(fabric_clock),
    .rst(rst),
    .inValid(pendValid_r),
    .inReady(fifoReady),
    .inData(pendWord_r),
    .outValid(fifoValid),
    .outReady(rxReady),
    .outData(fifoData)
  );

  assign pop = fifoValid && rxReady;

  always_comb
  begin
    rxOut_nxt.data = rxOut_r.data;
    rxOut_nxt.valid = '0;
    if (pop)
    begin
      rxOut_nxt.data = fifoData;
      rxOut_nxt.valid = '1;
    end
  end

  always_ff @(posedge fabric_clock or posedge rst)
  begin
    if (rst)
      rxOut_r <= '0;
    else
      rxOut_r <= rxOut_nxt;
  end

  assign rxOut = rxOut_r;

  // ****************************************************************
  // assertions
  // ****************************************************************
  AST_GATE_QUAL: assert property (@(posedge fabric_clock) disable iff (rst)
    ((stbS2_r && !stbPrev_r && !$past(stbGate[0], GATE_LAT_CYC)) |=>
      $stable(lowHalf_r)) and
    ((!stbS2_r && stbPrev_r && !$past(stbGate[1], GATE_LAT_CYC)) |=>
      $stable(pendWord_r)))
    else $error("strobe edge accepted outside gate");

  AST_GATE_LAT: assert property (@(posedge fabric_clock) disable iff (rst)
    ready_r |-> gateAtFifo == $past(stbGate, GATE_LAT_CYC))
    else $error("gate latency at fifo wrong");

  AST_TX_OE: assert property (@(posedge fabric_clock) disable iff (rst)
    ready_r |=> (dqOe == $past(txIn.dqOe)) && (stbOe == $past(txIn.stbOe)))
    else $error("pad enable not taken from fabric");

  AST_TX_HOLD: assert property (@(posedge fabric_clock) disable iff (rst)
    !ready_r |=> (dqOe == '0) && (stbOe == '0))
    else $error("pad enable driven before ready");

  AST_RX_VALID: assert property (@(posedge fabric_clock) disable iff (rst)
    pop |=> (rxOut.valid == '1) && (rxOut.data == $past(fifoData)))
    else $error("popped word not presented as valid");

  AST_RX_IDLE: assert property (@(posedge fabric_clock) disable iff (rst)
    !pop |=> rxOut.valid == '0)
    else $error("valid without a popped word");

  AST_READY: assert property (@(posedge fabric_clock) disable iff (rst)
    $rose(phyReady) |-> $past(initCnt_r) == INIT_LAST)
    else $error("ready rose at wrong time");

  AST_PAIR: assert property (@(posedge fabric_clock) disable iff (rst)
    (wordDone && !(pendValid_r && !fifoReady)) |=>
      pendValid_r && pendWord_r == {$past(dqS2_r), $past(lowHalf_r)})
    else $error("word not paired from two strobe edges");

endmodule : octal_ddr_phy_data_lane

/* bench/mem_strobe_model.sv */
// memory-side strobe and data driver for the receive path
`timescale 1ns/1ps
module mem_strobe_model (
  output logic stbIn,
  output logic [octal_phy_pkg::DQ_PADS-1:0] dqIn
);
  logic [15:0] words[$];
  logic [15:0] w;

  initial
  begin
    stbIn = 1'b0;
    dqIn = 8'h00;
  end

  // one rise and one fall per word, 800 ns strobe period
  task automatic run(input bit oddRise);
    #37;
    while (words.size() > 0)
    begin
      w = words.pop_front();
      dqIn = w[7:0];
      #200 stbIn = 1'b1;
      #200 dqIn = w[15:8];
      #200 stbIn = 1'b0;
      #200;
    end
    dqIn = ~dqIn;
    if (oddRise)
    begin
      #200 stbIn = 1'b1;
      #200 dqIn = ~dqIn;
    end
  endtask : run

  // strobe released, idles low
  task automatic idle();
    stbIn = 1'b0;
  endtask : idle
endmodule : mem_strobe_model

/* bench/octal_ddr_phy_data_lane_tb.sv */
// self-checking bench of the octal ddr data lane
`timescale 1ns/1ps
module octal_ddr_phy_data_lane_tb;
  import octal_phy_pkg::*;
  logic fabric_clock, rst, rxReady, stbIn, phyReady;
  logic rxOverflow, rxFrameError, stbRxRaw;
  logic [STB_PADS-1:0] stbGate, stbOutRise, stbOutFall, stbOe;
  logic [DQ_PADS-1:0] dqIn, dqOutRise, dqOutFall, dqOe, dqRxRaw;
  tx_pad_t txIn;
  rx_word_t rxOut;
  int num_errors, num_checks;
  logic [15:0] got[$];
  logic [15:0] exp[$];

  octal_ddr_phy_data_lane #(.FIFO_DEPTH(8)) dut (.fabric_clock(fabric_clock),
    .rst(rst), .phyReady(phyReady), .txIn(txIn), .stbGate(stbGate),
    .dqIn(dqIn), .dqOutRise(dqOutRise), .dqOutFall(dqOutFall),
    .dqOe(dqOe), .stbIn(stbIn), .stbOutRise(stbOutRise),
    .stbOutFall(stbOutFall), .stbOe(stbOe), .stbRxRaw(stbRxRaw),
    .dqRxRaw(dqRxRaw), .rxOut(rxOut), .rxReady(rxReady),
    .rxOverflow(rxOverflow), .rxFrameError(rxFrameError));

  mem_strobe_model mem (.stbIn(stbIn), .dqIn(dqIn));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want)
    begin
      num_errors++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic tally_and_finish();
    if (num_errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  // gate opened ahead of the first strobe edge, closed after the last edge
  task automatic burst(input int n, input bit odd);
    logic [15:0] w;
    stbGate = 2'h3;
    repeat (6) @(posedge fabric_clock);
    for (int i = 0; i < n; i++)
    begin
      w = 16'($urandom);
      mem.words.push_back(w);
      exp.push_back(w);
    end
    mem.run(odd);
    repeat (4) @(posedge fabric_clock);
    #10 stbGate = 2'h0;
    repeat (8) @(posedge fabric_clock);
    #10 mem.idle();
  endtask : burst

  task automatic drain();
    rxReady = 1'b1;
    repeat (40) @(posedge fabric_clock);
    #10 check(got.size(), exp.size());
    check({stbRxRaw, dqRxRaw}, {stbIn, dqIn});
    while (exp.size() > 0 && got.size() > 0)
      check(got.pop_front(), exp.pop_front());
    got.delete();
    exp.delete();
  endtask : drain

  always @(negedge fabric_clock)
    if (rxOut.valid === 16'hFFFF)
      got.push_back(rxOut.data);
    else if (rxOut.valid !== 16'h0000)
      check(rxOut.valid, 16'hFFFF);

  // ****************************************************************
  // clock, watchdog, sequence
  // ****************************************************************
  initial
  begin
    fabric_clock = 1'b0;
    forever #50 fabric_clock = ~fabric_clock;
  end

  initial
  begin
    #2_000_000;
    num_errors++;
    tally_and_finish();
  end

  initial
  begin
    void'($urandom(32'hD3BE));
    rst = 1'b1;
    rxReady = 1'b0;
    stbGate = 2'h0;
    txIn = '1;
    repeat (4) @(posedge fabric_clock);
    #10 check({phyReady, dqOe, stbOe}, 11'h000);
    rst = 1'b0;
    repeat (INIT_CYC - 1) @(posedge fabric_clock);
    #10 check({phyReady, dqOe, stbOe}, 11'h000);
    @(posedge fabric_clock);
    #10 check(phyReady, 1'b1);
    for (int i = 0; i < 30; i++)
    begin
      txIn = 28'($urandom);
      @(posedge fabric_clock);
      #10 check({dqOutFall, dqOutRise}, txIn.dqPair);
      check({dqOe, stbOe}, {txIn.dqOe, txIn.stbOe});
      check({stbOutFall, stbOutRise}, txIn.stbPair);
    end
    txIn = '0;
    mem.words.push_back(16'hA55A);
    mem.words.push_back(16'h5AA5);
    mem.run(1'b0);
    mem.idle();
    drain();
    burst(4, 1'b0);
    drain();
    rxReady = 1'b0;
    burst(10, 1'b0);
    void'(exp.pop_back());
    check(rxOverflow, 1'b1);
    drain();
    check(rxFrameError, 1'b0);
    burst(2, 1'b1);
    drain();
    check({rxOverflow, rxFrameError}, 2'b11);
    rst = 1'b1;
    @(posedge fabric_clock);
    #10 check({rxOverflow, rxFrameError, phyReady}, 3'b000);
    rst = 1'b0;
    repeat (INIT_CYC - 1) @(posedge fabric_clock);
    #10 check({phyReady, dqOe, stbOe}, 11'h000);
    @(posedge fabric_clock);
    #10 check(phyReady, 1'b1);
    tally_and_finish();
  end
endmodule : octal_ddr_phy_data_lane_tb
